// ==== design/wldx_core.sv ====
// Word-load decode and execute core.
// Assumes one outstanding memory request; the memory path answers with
// a one-cycle rsp_valid pulse carrying data and fault flags.
// Operation
// - general load: base plus 16-bit offset
// - load word, sign-extend into general register
// - pre-R6: misaligned load gives address error
// - R6 may support misaligned loads
// - general load exceptions limited to listed set
// - float load fills low half only
// - coprocessor loads list their exceptions
// - second-coprocessor load decode, 11-bit offset
// - coprocessor load writes low word
// - user-space load decode, 9-bit offset
// - user-space load uses user mapping
// - user-space load only if feature present
// - user-space load needs access, allowed modes
// - pc-relative load decode, 19-bit offset
// - pc address: shifted offset plus masked pc
// - pc load aligned, sign-extends result
// - pc load may raise read inhibit
// - pc load matches data watchpoints only
// - fused add/subtract decode by function code
// - upper-immediate is add-upper with zero source
// - upper-immediate: immediate over sixteen zeros
`timescale 1ns/1ps
module wldx_core (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic instr_valid_in,
  input wire logic [31:0] instr_in,
  input wire logic [31:0] pc_in,
  input wire logic [31:0] base_val_in,
  input wire logic release6_in,
  input wire logic misalign_support_in,
  input wire logic enhanced_addressing_present_in,
  input wire logic sys_cop_enabled_in,
  input wire logic float_cop_enabled_in,
  input wire logic second_cop_enabled_in,
  input wire logic [2:0] seg_mode_in,
  input wire logic rsp_valid_in,
  input wire logic [31:0] rsp_data_in,
  input wire logic rsp_refill_in,
  input wire logic rsp_invalid_in,
  input wire logic rsp_read_inhibit_in,
  input wire logic rsp_bus_err_in,
  input wire logic rsp_watch_in,
  output logic instr_ready_out,
  output logic req_valid_out,
  output logic [31:0] req_addr_out,
  output logic req_user_map_out,
  output logic req_data_ref_out,
  output logic done_out,
  output logic wr_en_out,
  output logic [1:0] wr_target_out,
  output logic [4:0] wr_index_out,
  output logic [31:0] wr_data_out,
  output logic [3:0] exc_out,
  output logic fp_op_out,
  output logic fp_sub_out,
  output logic [1:0] fp_fmt_out
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wldx_pkg::wldx_op_t dec_op;
  logic [31:0] dec_off;
  logic [4:0] dec_dst;
  logic [4:0] dec_base;

  wldx_decode u_dec (
    .instr_in(instr_in),
    .op_out(dec_op),
    .offset_out(dec_off),
    .dst_out(dec_dst),
    .base_out(dec_base)
  );

  // Float load has no case in wldx_decode; the decoded base
  // field is not needed. It is recognised by the float load major code.
  logic is_float_load;
  assign is_float_load = (instr_in[31:26] == 6'h27);

  wldx_pkg::wldx_op_t op;
  always_comb begin
    op = dec_op;
    if (is_float_load)
      op = wldx_pkg::WLDX_OP_LWF;
  end

  // ----------------------------------------------------------------
  // Address and checks
  // ----------------------------------------------------------------
  logic [31:0] eff_addr;
  logic [31:0] float_off;
  logic is_mem;
  logic is_pc;
  logic misalign;
  logic mode_ok;
  logic pre_exc;
  wldx_pkg::wldx_exc_t pre_code;

  assign float_off = {{16{instr_in[15]}}, instr_in[15:0]};
  assign is_pc = (op == wldx_pkg::WLDX_OP_LDPC);
  assign is_mem = (op == wldx_pkg::WLDX_OP_LDW) ||
                  (op == wldx_pkg::WLDX_OP_LWF) ||
                  (op == wldx_pkg::WLDX_OP_LDCP2) ||
                  (op == wldx_pkg::WLDX_OP_LWU) || is_pc;

  always_comb begin
    if (is_pc)
      eff_addr = (pc_in & ~wldx_pkg::PC_LOW_MASK) + dec_off;
    else if (op == wldx_pkg::WLDX_OP_LWF)
      eff_addr = base_val_in + float_off;
    else
      eff_addr = base_val_in + dec_off;
  end

  assign misalign = !is_pc && (eff_addr[1:0] != 2'b00) &&
                    (!release6_in || !misalign_support_in);

  assign mode_ok =
    (seg_mode_in == wldx_pkg::MAPPED_USER_UNMAPPED_KERNEL_MODE) ||
    (seg_mode_in == wldx_pkg::UNMAPPED_USER_KERNEL_MODE) ||
    (seg_mode_in == wldx_pkg::MAPPED_USER_KERNEL_MODE);

  always_comb begin
    pre_exc = 1'b0;
    pre_code = wldx_pkg::WLDX_EXC_NONE;
    unique case (op)
      wldx_pkg::WLDX_OP_LWU: begin
        if (!enhanced_addressing_present_in || !mode_ok) begin
          pre_exc = 1'b1;
          pre_code = wldx_pkg::WLDX_EXC_RESERVED;
        end else if (!sys_cop_enabled_in) begin
          pre_exc = 1'b1;
          pre_code = wldx_pkg::WLDX_EXC_COP_UNUSABLE;
        end
      end
      wldx_pkg::WLDX_OP_LWF,
      wldx_pkg::WLDX_OP_FMADD,
      wldx_pkg::WLDX_OP_FMSUB: begin
        if (!float_cop_enabled_in) begin
          pre_exc = 1'b1;
          pre_code = wldx_pkg::WLDX_EXC_COP_UNUSABLE;
        end
      end
      wldx_pkg::WLDX_OP_LDCP2: begin
        if (!second_cop_enabled_in) begin
          pre_exc = 1'b1;
          pre_code = wldx_pkg::WLDX_EXC_COP_UNUSABLE;
        end
      end
      wldx_pkg::WLDX_OP_NONE: begin
        pre_exc = 1'b1;
        pre_code = wldx_pkg::WLDX_EXC_RESERVED;
      end
      default: begin
        pre_exc = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  wldx_pkg::wldx_state_t state_r, state_nxt;
  wldx_pkg::wldx_op_t op_r, op_nxt;
  logic [4:0] dst_r, dst_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [31:0] data_r, data_nxt;
  logic [3:0] exc_r, exc_nxt;
  logic wr_r, wr_nxt;
  logic [1:0] tgt_r, tgt_nxt;
  logic [1:0] fmt_r, fmt_nxt;
  wldx_pkg::wldx_exc_t rsp_code;

  wldx_exc u_exc (
    .op_in(op_r),
    .misalign_in(1'b0),
    .refill_in(rsp_refill_in),
    .invalid_in(rsp_invalid_in),
    .read_inhibit_in(rsp_read_inhibit_in),
    .bus_err_in(rsp_bus_err_in),
    .watch_in(rsp_watch_in),
    .exc_out(rsp_code)
  );

  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    dst_nxt = dst_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    exc_nxt = exc_r;
    wr_nxt = 1'b0;
    tgt_nxt = tgt_r;
    fmt_nxt = fmt_r;
    unique case (state_r)
      wldx_pkg::WLDX_ST_IDLE: begin
        if (instr_valid_in) begin
          op_nxt = op;
          dst_nxt = dec_dst;
          addr_nxt = eff_addr;
          fmt_nxt = instr_in[10:9];
          data_nxt = 32'h0000_0000;
          tgt_nxt = wldx_pkg::WLDX_DST_GEN;
          if (op == wldx_pkg::WLDX_OP_LWF)
            tgt_nxt = wldx_pkg::WLDX_DST_FLT;
          if (op == wldx_pkg::WLDX_OP_LDCP2)
            tgt_nxt = wldx_pkg::WLDX_DST_CP2;
          if (pre_exc) begin
            exc_nxt = pre_code;
            state_nxt = wldx_pkg::WLDX_ST_DONE;
          end else if (is_mem && misalign) begin
            exc_nxt = wldx_pkg::WLDX_EXC_ADDR;
            state_nxt = wldx_pkg::WLDX_ST_DONE;
          end else if (is_mem) begin
            exc_nxt = wldx_pkg::WLDX_EXC_NONE;
            state_nxt = wldx_pkg::WLDX_ST_MEM;
          end else begin
            exc_nxt = wldx_pkg::WLDX_EXC_NONE;
            data_nxt = dec_off;
            wr_nxt = (op == wldx_pkg::WLDX_OP_UPIMM);
            state_nxt = wldx_pkg::WLDX_ST_DONE;
          end
        end
      end
      wldx_pkg::WLDX_ST_MEM: begin
        if (rsp_valid_in) begin
          exc_nxt = rsp_code;
          // float target gets low word only
          data_nxt = rsp_data_in;
          wr_nxt = (rsp_code == wldx_pkg::WLDX_EXC_NONE);
          state_nxt = wldx_pkg::WLDX_ST_DONE;
        end
      end
      wldx_pkg::WLDX_ST_DONE: begin
        state_nxt = wldx_pkg::WLDX_ST_IDLE;
      end
      default: begin
        state_nxt = wldx_pkg::WLDX_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= wldx_pkg::WLDX_ST_IDLE;
      op_r <= wldx_pkg::WLDX_OP_NONE;
      dst_r <= 5'h00;
      addr_r <= 32'h0000_0000;
      data_r <= 32'h0000_0000;
      exc_r <= 4'h0;
      wr_r <= 1'b0;
      tgt_r <= 2'h0;
      fmt_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      dst_r <= dst_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      exc_r <= exc_nxt;
      wr_r <= wr_nxt;
      tgt_r <= tgt_nxt;
      fmt_r <= fmt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign instr_ready_out = (state_r == wldx_pkg::WLDX_ST_IDLE);
  assign req_valid_out = (state_r == wldx_pkg::WLDX_ST_MEM);
  assign req_addr_out = addr_r;
  assign req_user_map_out = (op_r == wldx_pkg::WLDX_OP_LWU);
  // every load here is a data reference
  assign req_data_ref_out = 1'b1;
  assign done_out = (state_r == wldx_pkg::WLDX_ST_DONE);
  assign wr_en_out = wr_r;
  assign wr_target_out = tgt_r;
  assign wr_index_out = dst_r;
  assign wr_data_out = data_r;
  assign exc_out = exc_r;
  assign fp_op_out = done_out && (exc_r == 4'h0) &&
                     ((op_r == wldx_pkg::WLDX_OP_FMADD) ||
                      (op_r == wldx_pkg::WLDX_OP_FMSUB));
  assign fp_sub_out = (op_r == wldx_pkg::WLDX_OP_FMSUB);
  assign fp_fmt_out = fmt_r;

endmodule // wldx_core

// ==== design/wldx_decode.sv ====
// Combinational decoder for the word-load group.
// Assumes the instruction word is stable while valid is high.
`timescale 1ns/1ps
module wldx_decode (
  input wire logic [31:0] instr_in,
  output wldx_pkg::wldx_op_t op_out,
  output logic [31:0] offset_out,
  output logic [4:0] dst_out,
  output logic [4:0] base_out
);

  logic [5:0] major;
  assign major = instr_in[31:26];
  assign dst_out = instr_in[25:21];
  assign base_out = instr_in[20:16];

  always_comb begin
    op_out = wldx_pkg::WLDX_OP_NONE;
    offset_out = 32'h0000_0000;
    if (major == wldx_pkg::WORD_LOAD_MAJOR_OPCODE) begin
      op_out = wldx_pkg::WLDX_OP_LDW;
      offset_out = {{16{instr_in[15]}}, instr_in[15:0]};
    end else if (major == wldx_pkg::COPROC_MEMORY_MAJOR_GROUP) begin
      if (instr_in[15:12] == wldx_pkg::CP2_LOAD_SUBOP && !instr_in[11]) begin
        op_out = wldx_pkg::WLDX_OP_LDCP2;
        offset_out = {{21{instr_in[10]}}, instr_in[10:0]};
      end
    end else if (major == wldx_pkg::USER_LOAD_MAJOR_GROUP) begin
      if (instr_in[15:12] == wldx_pkg::EXTENDED_LOAD_SUBGROUP &&
          instr_in[11:9] == wldx_pkg::LOAD_WORD_USER_SPACE_MINOR) begin
        op_out = wldx_pkg::WLDX_OP_LWU;
        offset_out = {{23{instr_in[8]}}, instr_in[8:0]};
      end
    end else if (major == wldx_pkg::PC_RELATIVE_MAJOR_GROUP) begin
      if (instr_in[20:19] == wldx_pkg::LOAD_WORD_PC_RELATIVE_SUB) begin
        op_out = wldx_pkg::WLDX_OP_LDPC;
        offset_out = {{11{instr_in[18]}}, instr_in[18:0], 2'b00};
      end
    end else if (major == wldx_pkg::FLOAT_MAJOR_GROUP) begin
      if (instr_in[8:0] == wldx_pkg::FUSED_MULTIPLY_ADD_FN)
        op_out = wldx_pkg::WLDX_OP_FMADD;
      else if (instr_in[8:0] == wldx_pkg::FUSED_MULTIPLY_SUBTRACT_FN)
        op_out = wldx_pkg::WLDX_OP_FMSUB;
    end else if (major == wldx_pkg::ADD_UPPER_IMMEDIATE_OP &&
                 instr_in[20:16] == 5'h00) begin
      op_out = wldx_pkg::WLDX_OP_UPIMM;
      offset_out = {instr_in[15:0], 16'h0000};
    end
  end

endmodule // wldx_decode

// ==== design/wldx_exc.sv ====
// Exception priority picker for the word-load group.
// Assumes translation and memory flags are valid with the response.
`timescale 1ns/1ps
module wldx_exc (
  input wire wldx_pkg::wldx_op_t op_in,
  input wire logic misalign_in,
  input wire logic refill_in,
  input wire logic invalid_in,
  input wire logic read_inhibit_in,
  input wire logic bus_err_in,
  input wire logic watch_in,
  output wldx_pkg::wldx_exc_t exc_out
);

  logic coproc_op;
  logic has_bus;
  assign coproc_op = (op_in == wldx_pkg::WLDX_OP_LWF) ||
                     (op_in == wldx_pkg::WLDX_OP_LDCP2);
  // coprocessor loads carry no bus error
  assign has_bus = !coproc_op;

  always_comb begin
    exc_out = wldx_pkg::WLDX_EXC_NONE;
    if (misalign_in)
      exc_out = wldx_pkg::WLDX_EXC_ADDR;
    else if (refill_in)
      exc_out = wldx_pkg::WLDX_EXC_REFILL;
    else if (invalid_in)
      exc_out = wldx_pkg::WLDX_EXC_INVALID;
    else if (read_inhibit_in && op_in == wldx_pkg::WLDX_OP_LDPC)
      exc_out = wldx_pkg::WLDX_EXC_READ_INHIBIT;
    else if (watch_in)
      exc_out = wldx_pkg::WLDX_EXC_WATCH;
    else if (bus_err_in && has_bus)
      exc_out = wldx_pkg::WLDX_EXC_BUS;
  end

endmodule // wldx_exc

// ==== design/wldx_pkg.sv ====
// Package for the word-load decode and execute block.
// Assumes a 32-bit general register file and 32-bit instruction words.
package wldx_pkg;

  // ----------------------------------------------------------------
  // Opcode fields
  // ----------------------------------------------------------------
  localparam logic [5:0] WORD_LOAD_MAJOR_OPCODE = 6'h3f;
  localparam logic [5:0] COPROC_MEMORY_MAJOR_GROUP = 6'h08;
  localparam logic [5:0] USER_LOAD_MAJOR_GROUP = 6'h18;
  localparam logic [5:0] PC_RELATIVE_MAJOR_GROUP = 6'h1e;
  localparam logic [5:0] FLOAT_MAJOR_GROUP = 6'h15;
  localparam logic [5:0] ADD_UPPER_IMMEDIATE_OP = 6'h04;
  localparam logic [3:0] CP2_LOAD_SUBOP = 4'h0;
  localparam logic [3:0] EXTENDED_LOAD_SUBGROUP = 4'h6;
  localparam logic [2:0] LOAD_WORD_USER_SPACE_MINOR = 3'h7;
  localparam logic [1:0] LOAD_WORD_PC_RELATIVE_SUB = 2'h1;
  localparam logic [8:0] FUSED_MULTIPLY_ADD_FN = 9'h1b8;
  localparam logic [8:0] FUSED_MULTIPLY_SUBTRACT_FN = 9'h1f8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MAJOR_LSB = 26;
  localparam int RT_LSB = 21;
  localparam int BASE_LSB = 16;
  localparam int SUB_LSB = 12;
  localparam int MINOR_LSB = 9;
  localparam int PCSUB_LSB = 19;
  localparam int UPPER_SHIFT = 16;
  localparam int PC_OFFSET_SHIFT = 2;
  localparam logic [31:0] PC_LOW_MASK = 32'h0000_0003;

  // ----------------------------------------------------------------
  // Segment access modes
  // ----------------------------------------------------------------
  localparam logic [2:0] MAPPED_USER_UNMAPPED_KERNEL_MODE = 3'h1;
  localparam logic [2:0] UNMAPPED_USER_KERNEL_MODE = 3'h2;
  localparam logic [2:0] MAPPED_USER_KERNEL_MODE = 3'h3;

  // ----------------------------------------------------------------
  // Operation kinds and targets
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    WLDX_OP_NONE = 4'h0,
    WLDX_OP_LDW = 4'h1,
    WLDX_OP_LWF = 4'h2,
    WLDX_OP_LDCP2 = 4'h3,
    WLDX_OP_LWU = 4'h4,
    WLDX_OP_LDPC = 4'h5,
    WLDX_OP_FMADD = 4'h6,
    WLDX_OP_FMSUB = 4'h7,
    WLDX_OP_UPIMM = 4'h8
  } wldx_op_t;

  typedef enum logic [1:0] {
    WLDX_DST_GEN = 2'h0,
    WLDX_DST_FLT = 2'h1,
    WLDX_DST_CP2 = 2'h2
  } wldx_dst_t;

  // Exception codes on the result port
  typedef enum logic [3:0] {
    WLDX_EXC_NONE = 4'h0,
    WLDX_EXC_REFILL = 4'h1,
    WLDX_EXC_INVALID = 4'h2,
    WLDX_EXC_READ_INHIBIT = 4'h3,
    WLDX_EXC_BUS = 4'h4,
    WLDX_EXC_ADDR = 4'h5,
    WLDX_EXC_WATCH = 4'h6,
    WLDX_EXC_RESERVED = 4'h7,
    WLDX_EXC_COP_UNUSABLE = 4'h8
  } wldx_exc_t;

  // One-hot execution states
  typedef enum logic [2:0] {
    WLDX_ST_IDLE = 3'b001,
    WLDX_ST_MEM = 3'b010,
    WLDX_ST_DONE = 3'b100
  } wldx_state_t;

endpackage

// ==== sim/wldx_core_checker.sv ====
// Assertions on the word-load core ports.
// Assumes one instruction in flight and the load walk of the core.
`timescale 1ns/1ps
module wldx_core_checker (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic instr_valid_in,
  input wire logic [31:0] instr_in,
  input wire logic [31:0] pc_in,
  input wire logic [31:0] base_val_in,
  input wire logic release6_in,
  input wire logic enhanced_addressing_present_in,
  input wire logic sys_cop_enabled_in,
  input wire logic float_cop_enabled_in,
  input wire logic [2:0] seg_mode_in,
  input wire logic instr_ready_out,
  input wire logic req_valid_out,
  input wire logic [31:0] req_addr_out,
  input wire logic req_user_map_out,
  input wire logic req_data_ref_out,
  input wire logic done_out,
  input wire logic wr_en_out,
  input wire logic [31:0] wr_data_out,
  input wire logic [3:0] exc_out,
  input wire logic fp_op_out,
  input wire logic fp_sub_out,
  input wire logic [1:0] fp_fmt_out
);
  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  wire [5:0] maj = instr_in[31:26];
  wire tk = instr_valid_in && instr_ready_out;
  wire [31:0] gl_ea = base_val_in + {{16{instr_in[15]}}, instr_in[15:0]};
  wire [31:0] ue_ea = base_val_in + {{23{instr_in[8]}}, instr_in[8:0]};
  wire [31:0] pc_ea = (pc_in & ~32'h3) +
    {{11{instr_in[18]}}, instr_in[18:0], 2'b00};
  wire ue = maj == 6'h18 && instr_in[15:9] == 7'h37;
  wire fl = tk && maj == 6'h15 && float_cop_enabled_in;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_gl_addr;
    tk && maj == 6'h3f && gl_ea[1:0] == 2'h0
      |=> req_valid_out && req_addr_out == $past(gl_ea);
  endproperty
  a_gl_addr: assert property (p_gl_addr) else $error("load address");
  property p_misalign;
    tk && maj == 6'h3f && !release6_in && gl_ea[1:0] != 2'h0
      |=> done_out && exc_out == 4'h5 && !wr_en_out && !req_valid_out;
  endproperty
  a_misalign: assert property (p_misalign) else $error("no trap");
  property p_pc_addr;
    tk && maj == 6'h1e && instr_in[20:19] == 2'h1
      |=> req_valid_out && req_addr_out == $past(pc_ea);
  endproperty
  a_pc_addr: assert property (p_pc_addr) else $error("pc address");
  property p_data_ref;
    tk && maj == 6'h1e && instr_in[20:19] == 2'h1
      |=> req_valid_out && req_data_ref_out;
  endproperty
  a_data_ref: assert property (p_data_ref) else $error("not data");
  property p_fadd;
    fl && instr_in[8:0] == 9'h1b8 |=> fp_op_out && !fp_sub_out &&
      fp_fmt_out == $past(instr_in[10:9]) ##1 !fp_op_out;
  endproperty
  a_fadd: assert property (p_fadd) else $error("fused add");
  property p_fsub;
    fl && instr_in[8:0] == 9'h1f8 |=> fp_op_out && fp_sub_out;
  endproperty
  a_fsub: assert property (p_fsub) else $error("fused sub");
  property p_lui;
    tk && maj == 6'h04 && instr_in[20:16] == 5'h0 |=> done_out &&
      wr_en_out && exc_out == 4'h0 &&
      wr_data_out == {$past(instr_in[15:0]), 16'h0};
  endproperty
  a_lui: assert property (p_lui) else $error("upper imm");
  property p_ue_absent;
    tk && ue && !enhanced_addressing_present_in
      |=> done_out && exc_out == 4'h7 && !req_valid_out;
  endproperty
  a_ue_absent: assert property (p_ue_absent) else $error("absent");
  property p_ue_map;
    tk && ue && enhanced_addressing_present_in && sys_cop_enabled_in &&
      seg_mode_in inside {3'h1, 3'h2, 3'h3} && ue_ea[1:0] == 2'h0
      |=> req_valid_out && req_user_map_out && req_addr_out == $past(ue_ea);
  endproperty
  a_ue_map: assert property (p_ue_map) else $error("user map");

  c_ue: cover property (tk && ue);
  c_trap: cover property (done_out && exc_out == 4'h5);
  c_fsub: cover property (fp_op_out && fp_sub_out);
endmodule // wldx_core_checker

bind wldx_core wldx_core_checker wldx_core_checker_inst (.*);

// ==== sim/wldx_mem_model.sv ====
// Memory load path model answering the core's requests.
// Assumes the request is held until the answer pulse.
`timescale 1ns/1ps
module wldx_mem_model (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire logic [3:0] dly_in,
  input wire logic [31:0] data_in,
  input wire logic [4:0] fault_in,
  output logic rsp_valid_out,
  output logic [31:0] rsp_data_out,
  output logic [4:0] rsp_flags_out
);
  logic [3:0] cnt_r;
  logic [31:0] last_r;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= 4'h0;
      rsp_valid_out <= 1'b0;
      last_r <= 32'h0;
    end else if (rsp_valid_out) begin
      rsp_valid_out <= 1'b0;
      cnt_r <= 4'h0;
    end else if (req_valid_in && cnt_r == dly_in) begin
      rsp_valid_out <= 1'b1;
      last_r <= data_in;
    end else if (req_valid_in) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  // Stale values inverted so a late sample cannot pass
  assign rsp_data_out = rsp_valid_out ? last_r : ~last_r;
  assign rsp_flags_out = rsp_valid_out ? fault_in : ~fault_in;
endmodule // wldx_mem_model

// ==== sim/word_load_decode_exec_tb.sv ====
// Testbench for the word-load core with a memory model.
// Assumes the checker is bound to the core.
`timescale 1ns/1ps
module word_load_decode_exec_tb;
  logic sys_clk_in, rst_n_in, instr_valid_in, release6_in;
  logic misalign_support_in, enhanced_addressing_present_in;
  logic sys_cop_enabled_in, float_cop_enabled_in, second_cop_enabled_in;
  logic rsp_valid_in, rsp_refill_in, rsp_invalid_in, rsp_read_inhibit_in;
  logic rsp_bus_err_in, rsp_watch_in, instr_ready_out, req_valid_out;
  logic req_user_map_out, req_data_ref_out, done_out, wr_en_out;
  logic fp_op_out, fp_sub_out;
  logic [31:0] instr_in, pc_in, base_val_in, rsp_data_in, req_addr_out;
  logic [31:0] wr_data_out, mem_word, seen_addr;
  logic [2:0] seg_mode_in;
  logic [4:0] wr_index_out, fault;
  logic [3:0] exc_out, dly;
  logic [1:0] wr_target_out, fp_fmt_out;
  int failures, cmp_count;

  wldx_core wldx_core_inst (.*);
  wldx_mem_model wldx_mem_model_inst (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .req_valid_in(req_valid_out), .dly_in(dly), .data_in(mem_word),
    .fault_in(fault), .rsp_valid_out(rsp_valid_in),
    .rsp_data_out(rsp_data_in),
    .rsp_flags_out({rsp_refill_in, rsp_invalid_in, rsp_read_inhibit_in,
      rsp_bus_err_in, rsp_watch_in}));

  always #5 sys_clk_in = ~sys_clk_in;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_res(input logic en, input logic [1:0] tgt,
      input logic [4:0] idx, input logic [31:0] data, input logic [3:0] exc);
    chk("exception", {28'h0, exc}, {28'h0, exc_out});
    chk("write enable", {31'h0, en}, {31'h0, wr_en_out});
    if (en) begin
      chk("target", {30'h0, tgt}, {30'h0, wr_target_out});
      chk("index", {27'h0, idx}, {27'h0, wr_index_out});
      chk("data", data, wr_data_out);
    end
  endtask

  task automatic cfg(input logic r6, ms, enh, sys, input logic [2:0] m);
    release6_in = r6;
    misalign_support_in = ms;
    enhanced_addressing_present_in = enh;
    sys_cop_enabled_in = sys;
    seg_mode_in = m;
  endtask

  // Offers one instruction and waits for its done pulse
  task automatic issue(input logic [31:0] ins, base, word,
      input logic [4:0] flt);
    int n;
    n = 0;
    seen_addr = 32'hffff_ffff;
    @(negedge sys_clk_in);
    instr_in = ins;
    base_val_in = base;
    mem_word = word;
    fault = flt;
    instr_valid_in = 1'b1;
    @(negedge sys_clk_in);
    instr_valid_in = 1'b0;
    while (done_out !== 1'b1 && n < 40) begin
      if (req_valid_out === 1'b1) seen_addr = req_addr_out;
      @(negedge sys_clk_in);
      n++;
    end
    if (n == 40) begin
      failures++;
      $display("unexpected hang: expected done, seen none");
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_general();
    cfg(1'b0, 1'b0, 1'b0, 1'b1, 3'h1);
    dly = 4'h0;
    issue({6'h3f, 5'd5, 5'd3, 16'hfffc}, 32'h1000, 32'h8000_1234, 5'h0);
    chk_res(1'b1, 2'h0, 5'd5, 32'h8000_1234, 4'h0);
    dly = 4'h6;
    issue({6'h3f, 5'd5, 5'd3, 16'h0010}, 32'h2000, 32'h0, 5'h02);
    chk_res(1'b0, 2'h0, 5'd5, 32'h0, 4'h4);
    issue({6'h3f, 5'd5, 5'd3, 16'h0010}, 32'h2000, 32'h0, 5'h01);
    chk_res(1'b0, 2'h0, 5'd5, 32'h0, 4'h6);
    $display("test general load done");
  endtask

  task automatic t_align();
    issue({6'h3f, 5'd2, 5'd3, 16'h0002}, 32'h1000, 32'h55, 5'h0);
    chk_res(1'b0, 2'h0, 5'd2, 32'h0, 4'h5);
    cfg(1'b1, 1'b1, 1'b0, 1'b1, 3'h1);
    issue({6'h3f, 5'd2, 5'd3, 16'h0002}, 32'h1000, 32'h55, 5'h0);
    chk_res(1'b1, 2'h0, 5'd2, 32'h55, 4'h0);
    cfg(1'b1, 1'b0, 1'b0, 1'b1, 3'h1);
    issue({6'h3f, 5'd2, 5'd3, 16'h0002}, 32'h1000, 32'h55, 5'h0);
    chk_res(1'b0, 2'h0, 5'd2, 32'h0, 4'h5);
    $display("test alignment done");
  endtask

  task automatic t_cop();
    issue({6'h27, 5'd7, 5'd3, 16'h0008}, 32'h1000, 32'h1357_9bdf, 5'h0);
    chk_res(1'b1, 2'h1, 5'd7, 32'h1357_9bdf, 4'h0);
    float_cop_enabled_in = 1'b0;
    issue({6'h27, 5'd7, 5'd3, 16'h0008}, 32'h1000, 32'h0, 5'h0);
    chk_res(1'b0, 2'h1, 5'd7, 32'h0, 4'h8);
    float_cop_enabled_in = 1'b1;
    issue({6'h08, 5'd9, 5'd3, 5'h0, 11'h7fc}, 32'h1000, 32'h2468, 5'h0);
    chk_res(1'b1, 2'h2, 5'd9, 32'h2468, 4'h0);
    chk("address", 32'h0ffc, seen_addr);
    issue({6'h08, 5'd9, 5'd3, 5'h0, 11'h7fc}, 32'h1000, 32'h0, 5'h10);
    chk_res(1'b0, 2'h2, 5'd9, 32'h0, 4'h1);
    $display("test coprocessor loads done");
  endtask

  task automatic t_user();
    logic [31:0] ins;
    ins = {6'h18, 5'd4, 5'd3, 4'h6, 3'h7, 9'h1fc};
    cfg(1'b0, 1'b0, 1'b0, 1'b1, 3'h1);
    issue(ins, 32'h1000, 32'h0, 5'h0);
    chk_res(1'b0, 2'h0, 5'd4, 32'h0, 4'h7);
    cfg(1'b0, 1'b0, 1'b1, 1'b0, 3'h1);
    issue(ins, 32'h1000, 32'h0, 5'h0);
    chk_res(1'b0, 2'h0, 5'd4, 32'h0, 4'h8);
    cfg(1'b0, 1'b0, 1'b1, 1'b1, 3'h0);
    issue(ins, 32'h1000, 32'h0, 5'h0);
    chk_res(1'b0, 2'h0, 5'd4, 32'h0, 4'h7);
    for (int m = 1; m < 4; m++) begin
      cfg(1'b0, 1'b0, 1'b1, 1'b1, 3'(m));
      issue(ins, 32'h1000, 32'h9abc, 5'h0);
      chk_res(1'b1, 2'h0, 5'd4, 32'h9abc, 4'h0);
      chk("address", 32'h0ffc, seen_addr);
    end
    $display("test user-space load done");
  endtask

  task automatic t_pc();
    pc_in = 32'h2003;
    issue({6'h1e, 5'd6, 2'h1, 19'h7fffe}, 32'h0, 32'hfedc_ba98, 5'h0);
    chk_res(1'b1, 2'h0, 5'd6, 32'hfedc_ba98, 4'h0);
    chk("address", 32'h1ff8, seen_addr);
    issue({6'h1e, 5'd6, 2'h1, 19'h7fffe}, 32'h0, 32'h0, 5'h04);
    chk_res(1'b0, 2'h0, 5'd6, 32'h0, 4'h3);
    $display("test pc-relative load done");
  endtask

  task automatic t_misc();
    issue({6'h15, 15'h0443, 2'h1, 9'h1b8}, 32'h0, 32'h0, 5'h0);
    chk("fused", 32'h9, {28'h0, fp_op_out, fp_sub_out, fp_fmt_out});
    issue({6'h15, 15'h0443, 2'h0, 9'h1f8}, 32'h0, 32'h0, 5'h0);
    chk("fused", 32'hc, {28'h0, fp_op_out, fp_sub_out, fp_fmt_out});
    issue({6'h04, 5'd8, 5'd0, 16'habcd}, 32'h0, 32'h0, 5'h0);
    chk_res(1'b1, 2'h0, 5'd8, 32'habcd_0000, 4'h0);
    $display("test fused and upper immediate done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Some 21 instructions of under 20 cycles each; ample margin
  initial begin
    #50000;
    failures++;
    $display("unexpected watchdog: expected end, seen hang");
    give_verdict();
  end

  initial begin
    sys_clk_in = 1'b0;
    rst_n_in = 1'b0;
    instr_valid_in = 1'b0;
    instr_in = 32'h0;
    pc_in = 32'h0;
    base_val_in = 32'h0;
    mem_word = 32'h0;
    fault = 5'h0;
    dly = 4'h0;
    float_cop_enabled_in = 1'b1;
    second_cop_enabled_in = 1'b1;
    cfg(1'b0, 1'b0, 1'b0, 1'b1, 3'h1);
    repeat (12) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    t_general();
    t_align();
    t_cop();
    t_user();
    t_pc();
    t_misc();
    give_verdict();
  end
endmodule // word_load_decode_exec_tb
